// ---- inc/psq_pkg.sv ----
// types and constants shared by the program sequencer
package psq_pkg;

    localparam int PSQ_PC_W = 10;

    typedef enum logic [4:0] {
        OP_STEP        = 5'h00,
        OP_JUMP        = 5'h01,
        OP_CALL        = 5'h02,
        OP_RET         = 5'h03,
        OP_IRQ_RET     = 5'h04,
        OP_CMP_SKIP    = 5'h05,
        OP_INC_ACC     = 5'h06,
        OP_INC_MEM     = 5'h07,
        OP_DEC_ACC     = 5'h08,
        OP_DEC_MEM     = 5'h09,
        OP_BIT_CLR     = 5'h0a,
        OP_BIT_SET     = 5'h0b,
        OP_B0_BIT_CLR  = 5'h0c,
        OP_B0_BIT_SET  = 5'h0d,
        OP_ADD_LOWER   = 5'h0e,
        OP_SUB_LOWER   = 5'h0f,
        OP_MOVE_LOWER  = 5'h10,
        OP_TABLE_READ  = 5'h11,
        OP_MOV_IMM     = 5'h12,
        OP_LOAD_DIR    = 5'h13,
        OP_STORE_DIR   = 5'h14,
        OP_LOAD_IND    = 5'h15,
        OP_STORE_IND   = 5'h16
    } psq_op_e;

    typedef struct packed {
        logic          valid;
        psq_op_e       code;
        logic [7:0]    operand;
        logic [7:0]    addr;
        logic [9:0]    target;
        logic [2:0]    bit_sel;
        logic          carry_in;
    } psq_op_s;

    typedef struct packed {
        logic          we;
        logic [15:0]   addr;
        logic [7:0]    wdata;
    } psq_ram_s;

    typedef struct packed {
        logic [9:0]       pc;
        logic [7:0]       acc;
        logic [7:0]       thb;
        logic [7:0]       ofs;
        logic [7:0]       bank;
        logic [1:0]       sp;
        logic [3:0][9:0]  stk;
        psq_ram_s         ram;
        logic [31:0]      prdata;
    } psq_state_s;

    localparam logic [7:0] IDX_TABLE_HIGH = 8'h82;
    localparam logic [7:0] IDX_PTR_OFFSET = 8'h83;
    localparam logic [7:0] IDX_PTR_BANK   = 8'h84;
    localparam logic [7:0] IDX_ACC        = 8'h90;
    localparam logic [7:0] IDX_IP_LOWER   = 8'hce;
    localparam logic [7:0] IDX_IP_UPPER   = 8'hcf;
    localparam logic [7:0] IDX_STACK_PTR  = 8'hdf;
    localparam logic [7:0] IDX_INDIRECT   = 8'he7;
    localparam logic [7:0] WORK_LO        = 8'h80;
    localparam logic [7:0] WORK_HI        = 8'h87;
    localparam logic [7:0] BANK0          = 8'h00;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [7:0] BYTE_ONE       = 8'h01;
    localparam logic [9:0] PC_RESET       = 10'h000;
    localparam logic [9:0] IRQ_VECTOR     = 10'h004;
    localparam logic [9:0] ONE_STEP       = 10'h001;
    localparam logic [9:0] SKIP_STEP      = 10'h002;
    localparam logic [1:0] SP_RESET       = 2'h3;
    localparam logic [1:0] SP_ONE         = 2'h1;

endpackage

// ---- logic/psq_sequencer.sv ----
// program counter, pointer registers and return stack with apb access
`timescale 1ns/100ps
`default_nettype none

module psq_sequencer (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire psq_pkg::psq_op_s  op,
    input  wire logic              irq_take,
    input  wire logic [15:0]       rom_data,
    input  wire logic [7:0]        ram_rdata,
    output logic [9:0]             instruction_pointer,
    output logic [7:0]             alu_working_byte,
    output logic [15:0]            pointer_addr,
    output psq_pkg::psq_ram_s      ram
);
    import psq_pkg::*;

    psq_state_s s_q;
    psq_state_s s_d;

    function automatic logic [1:0] slot(input logic [1:0] sp);
        slot = ~sp;
    endfunction

    function automatic logic [9:0] skip_pc(input logic [9:0] pc);
        skip_pc = pc + SKIP_STEP;
    endfunction

    function automatic logic [7:0] reg_index(input logic [11:0] a);
        reg_index = a[9:2];
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                 (i == IDX_TABLE_HIGH || i == IDX_PTR_OFFSET ||
                  i == IDX_PTR_BANK || i == IDX_ACC ||
                  i == IDX_IP_LOWER || i == IDX_IP_UPPER ||
                  i == IDX_STACK_PTR || i == IDX_INDIRECT);
    endfunction

    // shared byte write path for instructions and software
    function automatic psq_state_s put_byte(input psq_state_s st,
                                            input logic [7:0] idx,
                                            input logic [7:0] d);
        psq_state_s r;
        r = st;
        case (idx)
            IDX_TABLE_HIGH: begin
                r.thb = d;
            end
            IDX_PTR_OFFSET: begin
                r.ofs = d;
            end
            IDX_PTR_BANK: begin
                r.bank = d;
            end
            IDX_ACC: begin
                r.acc = st.acc;
            end
            IDX_IP_LOWER: begin
                r.pc = {st.pc[9:8], d};
            end
            IDX_IP_UPPER: begin
                r.pc = {d[1:0], st.pc[7:0]};
            end
            IDX_STACK_PTR: begin
                r.sp = d[1:0];
            end
            IDX_INDIRECT: begin
                r.ram = {1'b1, st.bank, st.ofs, d};
            end
            default: begin
                r.ram = {1'b1, BANK0, idx, d};
            end
        endcase
        put_byte = r;
    endfunction

    logic              setup;
    logic              apb_wr;
    logic [9:0]        pc1;
    logic [7:0]        res;
    logic [8:0]        sum;

    assign setup  = psel && !penable;
    assign apb_wr = psel && penable && pwrite && mapped(paddr);
    assign pc1    = s_q.pc + ONE_STEP;

    always_comb begin
        s_d       = s_q;
        s_d.ram.we = 1'b0;
        res       = BYTE_ZERO;
        sum       = 9'h000;
        if (irq_take) begin
            // interrupted instruction runs again after return
            s_d.stk[slot(s_q.sp)] = s_q.pc;
            s_d.sp = s_q.sp - SP_ONE;
            s_d.pc = IRQ_VECTOR;
        end else if (op.valid) begin
            s_d.pc = pc1;
            case (op.code)
                OP_STEP: begin
                    s_d.pc = pc1;
                end
                OP_JUMP: begin
                    s_d.pc = op.target;
                end
                OP_CALL: begin
                    s_d.stk[slot(s_q.sp)] = pc1;
                    s_d.sp = s_q.sp - SP_ONE;
                    s_d.pc = op.target;
                end
                OP_RET, OP_IRQ_RET: begin
                    s_d.sp = s_q.sp + SP_ONE;
                    s_d.pc = s_q.stk[slot(s_q.sp + SP_ONE)];
                end
                OP_CMP_SKIP: begin
                    if (s_q.acc == op.operand) begin
                        s_d.pc = skip_pc(s_q.pc);
                    end
                end
                OP_INC_ACC, OP_INC_MEM: begin
                    res = op.operand + BYTE_ONE;
                    if (res == BYTE_ZERO) begin
                        s_d.pc = skip_pc(s_q.pc);
                    end
                    if (op.code == OP_INC_MEM) begin
                        s_d = put_byte(s_d, op.addr, res);
                    end else begin
                        s_d.acc = res;
                    end
                end
                OP_DEC_ACC, OP_DEC_MEM: begin
                    res = op.operand - BYTE_ONE;
                    if (op.operand == BYTE_ONE) begin
                        s_d.pc = skip_pc(s_q.pc);
                    end
                    if (op.code == OP_DEC_MEM) begin
                        s_d = put_byte(s_d, op.addr, res);
                    end else begin
                        s_d.acc = res;
                    end
                end
                OP_BIT_CLR, OP_B0_BIT_CLR: begin
                    if (!op.operand[op.bit_sel]) begin
                        s_d.pc = skip_pc(s_q.pc);
                    end
                end
                OP_BIT_SET, OP_B0_BIT_SET: begin
                    if (op.operand[op.bit_sel]) begin
                        s_d.pc = skip_pc(s_q.pc);
                    end
                end
                OP_ADD_LOWER: begin
                    // counter has already stepped, so the table starts next
                    sum = {1'b0, pc1[7:0]} + {1'b0, s_q.acc} + {8'h00, op.carry_in};
                    s_d.pc = {pc1[9:8] + {1'b0, sum[8]}, sum[7:0]};
                end
                OP_SUB_LOWER: begin
                    // upper byte only counts up; a borrow is dropped
                    s_d.pc = {pc1[9:8], pc1[7:0] - s_q.acc};
                end
                OP_MOVE_LOWER: begin
                    s_d.pc = {s_q.pc[9:8], s_q.acc};
                end
                OP_TABLE_READ: begin
                    s_d.thb = rom_data[15:8];
                    s_d.acc = rom_data[7:0];
                end
                OP_MOV_IMM: begin
                    if (op.addr >= WORK_LO && op.addr <= WORK_HI) begin
                        s_d = put_byte(s_d, op.addr, op.operand);
                    end
                end
                OP_LOAD_DIR, OP_LOAD_IND: begin
                    s_d.acc = op.operand;
                end
                OP_STORE_DIR: begin
                    s_d = put_byte(s_d, op.addr, s_q.acc);
                end
                OP_STORE_IND: begin
                    s_d = put_byte(s_d, IDX_INDIRECT, s_q.acc);
                end
                default: begin
                    s_d.pc = pc1;
                end
            endcase
        end
        // software write lands last and wins over the instruction; a write to the accumulator index leaves acc unchanged
        if (apb_wr) begin
            s_d = put_byte(s_d, reg_index(paddr), pwdata[7:0]);
        end
        if (setup) begin
            case (reg_index(paddr))
                IDX_TABLE_HIGH: s_d.prdata = 32'(s_q.thb);
                IDX_PTR_OFFSET: s_d.prdata = 32'(s_q.ofs);
                IDX_PTR_BANK:   s_d.prdata = 32'(s_q.bank);
                IDX_ACC:        s_d.prdata = 32'(s_q.acc);
                IDX_IP_LOWER:   s_d.prdata = 32'(s_q.pc[7:0]);
                IDX_IP_UPPER:   s_d.prdata = 32'(s_q.pc[9:8]);
                IDX_STACK_PTR:  s_d.prdata = 32'(s_q.sp);
                IDX_INDIRECT:   s_d.prdata = 32'(ram_rdata);
                default:        s_d.prdata = 32'h0000_0000;
            endcase
            if (!mapped(paddr)) begin
                s_d.prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.pc     <= PC_RESET;
            s_q.sp     <= SP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata              = s_q.prdata;
    assign pready              = 1'b1;
    assign pslverr             = psel && penable && !mapped(paddr);
    assign instruction_pointer = s_q.pc;
    assign alu_working_byte    = s_q.acc;
    assign pointer_addr        = {s_q.bank, s_q.ofs};
    assign ram                 = s_q.ram;

    // helper terms for the checks below
    logic       run;
    logic [9:0] add_ref;
    assign run     = op.valid && !irq_take && !apb_wr;
    assign add_ref = pc1 + {2'h0, s_q.acc} + {9'h000, op.carry_in};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_reset_start;
        !$past(presetn) |-> s_q.pc == PC_RESET && s_q.sp == SP_RESET;
    endproperty
    a_reset_start: assert property (p_reset_start) else $error("pc not zero after reset");

    property p_step;
        run && op.code == OP_STEP |=> s_q.pc == $past(s_q.pc) + ONE_STEP;
    endproperty
    a_step: assert property (p_step) else $error("counter did not step");

    property p_jump;
        run && op.code == OP_JUMP |=> s_q.pc == $past(op.target);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target not loaded");

    property p_cmp_skip;
        run && op.code == OP_CMP_SKIP && s_q.acc == op.operand
            |=> s_q.pc == $past(s_q.pc) + SKIP_STEP;
    endproperty
    a_cmp_skip: assert property (p_cmp_skip) else $error("compare skip missed");

    property p_bit_clr;
        run && op.code == OP_BIT_CLR && op.operand[op.bit_sel]
            |=> s_q.pc == $past(s_q.pc) + ONE_STEP;
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear test wrong");

    property p_inc_wrap;
        run && op.code == OP_INC_ACC && op.operand == 8'hff
            |=> s_q.pc == $past(s_q.pc) + SKIP_STEP && s_q.acc == BYTE_ZERO;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment skip wrong");

    property p_dec_noskip;
        run && op.code == OP_DEC_ACC && op.operand != BYTE_ONE
            |=> s_q.pc == $past(s_q.pc) + ONE_STEP;
    endproperty
    a_dec_noskip: assert property (p_dec_noskip) else $error("decrement skipped");

    property p_in_place;
        run && op.code == OP_INC_MEM && op.addr < WORK_LO
            |=> s_q.acc == $past(s_q.acc) && s_q.ram.we;
    endproperty
    a_in_place: assert property (p_in_place) else $error("in-place result misplaced");

    property p_add_carry;
        run && op.code == OP_ADD_LOWER |=> s_q.pc == $past(add_ref);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("lower add carry lost");

    property p_sub_keep;
        run && op.code == OP_SUB_LOWER |=> s_q.pc[9:8] == $past(pc1[9:8]);
    endproperty
    a_sub_keep: assert property (p_sub_keep) else $error("upper byte borrowed");

    property p_move_lower;
        run && op.code == OP_MOVE_LOWER |=> s_q.pc == {$past(s_q.pc[9:8]), $past(s_q.acc)};
    endproperty
    a_move_lower: assert property (p_move_lower) else $error("lower move jump wrong");

    property p_table;
        run && op.code == OP_TABLE_READ
            |=> s_q.thb == $past(rom_data[15:8]) && s_q.acc == $past(rom_data[7:0]);
    endproperty
    a_table: assert property (p_table) else $error("table read split wrong");

    property p_imm_range;
        run && op.code == OP_MOV_IMM && op.addr > WORK_HI |=> !s_q.ram.we;
    endproperty
    a_imm_range: assert property (p_imm_range) else $error("immediate out of range written");

    sequence s_call;
        run && op.code == OP_CALL;
    endsequence
    property p_call_ret;
        s_call ##1 (run && op.code == OP_RET) |=> s_q.pc == $past(s_q.pc, 2) + ONE_STEP;
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address wrong");

    property p_push_dec;
        s_call |=> s_q.sp == $past(s_q.sp) - SP_ONE;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

    property p_call_load;
        s_call |=> s_q.pc == $past(op.target);
    endproperty
    a_call_load: assert property (p_call_load) else $error("call target not loaded");

    property p_irq_push;
        irq_take && !apb_wr |=> s_q.pc == IRQ_VECTOR && s_q.sp == $past(s_q.sp) - SP_ONE;
    endproperty
    a_irq_push: assert property (p_irq_push) else $error("interrupt push wrong");

    property p_store_ind;
        run && op.code == OP_STORE_IND
            |=> s_q.ram == {1'b1, $past(s_q.bank), $past(s_q.ofs), $past(s_q.acc)};
    endproperty
    a_store_ind: assert property (p_store_ind) else $error("indirect store wrong");

    c_skip: cover property (run && op.code == OP_CMP_SKIP ##1 s_q.pc[0] == 1'b0);
    c_call_ret: cover property (s_call ##1 (run && op.code == OP_RET));
    c_page_carry: cover property (run && op.code == OP_ADD_LOWER && add_ref[9:8] != pc1[9:8]);
    c_irq: cover property (irq_take ##1 (run && op.code == OP_IRQ_RET));

endmodule

`default_nettype wire

// ---- verif/program_sequencer_pointers_bench.sv ----
// self-checking bench for the program sequencer
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module program_sequencer_pointers_bench;
    import psq_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    psq_op_s     op;
    logic        irq_take;
    logic [15:0] rom_data;
    logic [7:0]  ram_rdata;
    logic [9:0]  instruction_pointer;
    logic [7:0]  alu_working_byte;
    logic [15:0] pointer_addr;
    psq_ram_s    ram;
    logic [9:0]  pc_e;
    int          num_errors = 0;
    int          num_checks = 0;
    psq_op_e     bt [4] = '{OP_BIT_CLR, OP_BIT_SET, OP_B0_BIT_CLR, OP_B0_BIT_SET};

    psq_sequencer dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .op                  (op),
        .irq_take            (irq_take),
        .rom_data            (rom_data),
        .ram_rdata           (ram_rdata),
        .instruction_pointer (instruction_pointer),
        .alu_working_byte    (alu_working_byte),
        .pointer_addr        (pointer_addr),
        .ram                 (ram)
    );

    task automatic results();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one instruction, then an idle cycle so the expected counter only moves here
    task automatic run(psq_op_e c, logic [9:0] nxt, logic [7:0] opnd = 8'h00,
                       logic [7:0] a = 8'h00, logic [9:0] t = 10'h000,
                       logic [2:0] b = 3'h0, logic ci = 1'b0);
        @(posedge pclk);
        op <= '{1'b1, c, opnd, a, t, b, ci};
        @(posedge pclk);
        op.valid <= 1'b0;
        @(negedge pclk);
        pc_e = nxt;
        `CHK(instruction_pointer, pc_e)
    endtask

    // apb transfer; read data and error taken at the edge that sees pready
    task automatic apb(logic w, logic [7:0] idx, logic [7:0] wd, logic [31:0] rd_e,
                       logic err_e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        `CHK(pslverr, err_e)
        if (!w) `CHK(prdata, rd_e)
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // about 150 cycles expected; generous margin
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        results();
    end

    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h00000000;
        op        = '0;
        irq_take  = 1'b0;
        rom_data  = 16'h0000;
        ram_rdata = 8'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK(instruction_pointer, PC_RESET)
        pc_e = PC_RESET;
        apb(1'b0, IDX_STACK_PTR, 8'h00, 32'h3, 1'b0);
        run(OP_STEP, pc_e + 10'h001);
        run(OP_JUMP, 10'h2a5, 8'h00, 8'h00, 10'h2a5);
        run(OP_LOAD_DIR, pc_e + 10'h001, 8'h3c, 8'h20);
        `CHK(alu_working_byte, 8'h3c)
        run(OP_STORE_DIR, pc_e + 10'h001, 8'h00, 8'h30);
        `CHK(ram, {1'b1, 16'h0030, 8'h3c})
        @(negedge pclk);
        `CHK(ram.we, 1'b0)
        run(OP_CMP_SKIP, pc_e + 10'h002, 8'h3c);
        run(OP_CMP_SKIP, pc_e + 10'h001, 8'h3d);
        for (int k = 0; k < 4; k++) begin
            run(bt[k], pc_e + ((k % 2) ? 10'h002 : 10'h001), 8'h80, 8'h00, 10'h000, 3'h7);
            run(bt[k], pc_e + ((k % 2) ? 10'h001 : 10'h002), 8'hfe, 8'h00, 10'h000, 3'h0);
        end
        run(OP_INC_ACC, pc_e + 10'h002, 8'hff);
        `CHK(alu_working_byte, 8'h00)
        run(OP_INC_ACC, pc_e + 10'h001, 8'hfe);
        `CHK(alu_working_byte, 8'hff)
        run(OP_DEC_ACC, pc_e + 10'h002, 8'h01);
        `CHK(alu_working_byte, 8'h00)
        run(OP_DEC_ACC, pc_e + 10'h001, 8'h00);
        `CHK(alu_working_byte, 8'hff)
        run(OP_INC_MEM, pc_e + 10'h002, 8'hff, 8'h41);
        `CHK(ram, {1'b1, 16'h0041, 8'h00})
        `CHK(alu_working_byte, 8'hff)
        run(OP_DEC_MEM, pc_e + 10'h001, 8'h05, 8'h42);
        `CHK(ram, {1'b1, 16'h0042, 8'h04})
        @(posedge pclk);
        rom_data <= 16'h5aa5;
        run(OP_TABLE_READ, pc_e + 10'h001);
        `CHK(alu_working_byte, 8'ha5)
        apb(1'b0, IDX_TABLE_HIGH, 8'h00, 32'h5a, 1'b0);
        apb(1'b1, IDX_PTR_BANK, 8'h01, 32'h0, 1'b0);
        apb(1'b1, IDX_PTR_OFFSET, 8'h25, 32'h0, 1'b0);
        `CHK(pointer_addr, 16'h0125)
        apb(1'b1, IDX_INDIRECT, 8'h9b, 32'h0, 1'b0);
        `CHK(ram, {1'b1, 16'h0125, 8'h9b})
        @(posedge pclk);
        ram_rdata <= 8'hc7;
        apb(1'b0, IDX_INDIRECT, 8'h00, 32'hc7, 1'b0);
        run(OP_DEC_MEM, pc_e + 10'h002, 8'h01, IDX_PTR_OFFSET);
        `CHK(pointer_addr, 16'h0100)
        run(OP_MOV_IMM, pc_e + 10'h001, 8'h77, IDX_TABLE_HIGH);
        apb(1'b0, IDX_TABLE_HIGH, 8'h00, 32'h77, 1'b0);
        run(OP_MOV_IMM, pc_e + 10'h001, 8'h11, 8'h88);
        `CHK(ram.we, 1'b0)
        // computed jumps: carry crosses the page, borrow must not
        run(OP_JUMP, 10'h1ef, 8'h00, 8'h00, 10'h1ef);
        run(OP_LOAD_DIR, pc_e + 10'h001, 8'h20, 8'h20);
        run(OP_ADD_LOWER, 10'h211);
        run(OP_ADD_LOWER, 10'h233, 8'h00, 8'h00, 10'h000, 3'h0, 1'b1);
        run(OP_LOAD_DIR, pc_e + 10'h001, 8'h40, 8'h20);
        run(OP_SUB_LOWER, 10'h2f5);
        run(OP_LOAD_DIR, pc_e + 10'h001, 8'h20, 8'h20);
        run(OP_MOVE_LOWER, 10'h220);
        apb(1'b1, IDX_IP_LOWER, 8'h9c, 32'h0, 1'b0);
        `CHK(instruction_pointer, 10'h29c)
        apb(1'b1, IDX_IP_UPPER, 8'h01, 32'h0, 1'b0);
        `CHK(instruction_pointer, 10'h19c)
        pc_e = 10'h19c;
        apb(1'b1, IDX_ACC, 8'haa, 32'h0, 1'b0);
        `CHK(alu_working_byte, 8'h20)
        apb(1'b0, 8'h85, 8'h00, 32'h0, 1'b1);
        run(OP_CALL, 10'h050, 8'h00, 8'h00, 10'h050);
        apb(1'b0, IDX_STACK_PTR, 8'h00, 32'h2, 1'b0);
        run(OP_CALL, 10'h080, 8'h00, 8'h00, 10'h080);
        // interrupt wins over a jump offered in the same cycle
        @(posedge pclk);
        irq_take <= 1'b1;
        op       <= '{1'b1, OP_JUMP, 8'h00, 8'h00, 10'h3ff, 3'h0, 1'b0};
        @(posedge pclk);
        irq_take <= 1'b0;
        op.valid <= 1'b0;
        @(negedge pclk);
        `CHK(instruction_pointer, IRQ_VECTOR)
        apb(1'b0, IDX_STACK_PTR, 8'h00, 32'h0, 1'b0);
        run(OP_IRQ_RET, 10'h080);
        run(OP_RET, 10'h051);
        run(OP_RET, 10'h19d);
        apb(1'b0, IDX_STACK_PTR, 8'h00, 32'h3, 1'b0);
        // call and return back to back
        @(posedge pclk);
        op <= '{1'b1, OP_CALL, 8'h00, 8'h00, 10'h155, 3'h0, 1'b0};
        @(posedge pclk);
        op <= '{1'b1, OP_RET, 8'h00, 8'h00, 10'h000, 3'h0, 1'b0};
        @(posedge pclk);
        op.valid <= 1'b0;
        @(negedge pclk);
        `CHK(instruction_pointer, 10'h19e)
        pc_e = 10'h19e;
        run(OP_STORE_IND, pc_e + 10'h001);
        `CHK(ram, {1'b1, 16'h0100, 8'h20})
        run(OP_LOAD_IND, pc_e + 10'h001, 8'h6e);
        `CHK(alu_working_byte, 8'h6e)
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK(instruction_pointer, PC_RESET)
        results();
    end

endmodule

`default_nettype wire
